// *** verilog/esr_shift_register.sv ***
// Notes on behaviour
// - Sample input once per trigger rising edge.
// - Trigger falling edge changes nothing.
// - Direction low: load stage one, move up.
// - Direction high: load stage eight, move down.
// - Output equals the tapped stage.
// - Without retention, power loss clears stages.
// - With retention, all stages survive together.
// - Tap and retention fixed while live editing.
// - Live editing keeps the block running.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

`include "esr_map.svh"

module esr_shift_register #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    RST,
    input  wire logic                    SERIAL_IN,
    input  wire logic                    TRIGGER,
    input  wire logic                    DIRECTION,
    input  wire logic                    POWER_FAIL,
    output var  logic                    TAP_OUT,
    output var  esr_pkg::esr_stages_type STAGES,
    input  wire logic [11:0]             AWADDR,
    input  wire logic                    AWVALID,
    output var  logic                    AWREADY,
    input  wire logic [31:0]             WDATA,
    input  wire logic [3:0]              WSTRB,
    input  wire logic                    WVALID,
    output var  logic                    WREADY,
    output var  logic [1:0]              BRESP,
    output var  logic                    BVALID,
    input  wire logic                    BREADY,
    input  wire logic [11:0]             ARADDR,
    input  wire logic                    ARVALID,
    output var  logic                    ARREADY,
    output var  logic [31:0]             RDATA,
    output var  logic [1:0]              RRESP,
    output var  logic                    RVALID,
    input  wire logic                    RREADY
);
    import esr_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    esr_stages_type stages_r;
    esr_stages_type stages_nxt;
    logic           trg_prev_r;
    logic           pwr_prev_r;
    logic           run_r;
    logic           live_r;
    logic [2:0]     tap_r;
    logic           retain_r;
    logic           tap_out_r;
    logic           aw_held_r;
    logic [11:0]    aw_addr_r;
    logic           w_held_r;
    logic [31:0]    w_data_r;
    logic [3:0]     w_strb_r;
    logic           b_valid_r;
    logic [1:0]     b_resp_r;
    logic           r_valid_r;
    logic [31:0]    r_data_r;
    logic [1:0]     r_resp_r;
    logic           trg_rise;
    logic           pwr_loss;
    logic           ev_ready;
    logic           ev_valid;
    logic [1:0]     ev_data;
    logic           shift_ok;
    logic           fifo_full_n;
    logic [CW-1:0]  fifo_count;
    logic           do_write;

    // Edge detect against last cycle's level; a held high trigger never re-fires.
    assign trg_rise = TRIGGER && !trg_prev_r;
    assign pwr_loss = POWER_FAIL && !pwr_prev_r;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            trg_prev_r <= 1'b0;
            pwr_prev_r <= 1'b0;
        end else begin
            trg_prev_r <= TRIGGER;
            pwr_prev_r <= POWER_FAIL;
        end
    end

    // Each trigger edge while running queues the sampled bit with its direction. A full queue drops
    // the edge, a limitation accepted so that trigger timing is never stretched.
    assign ev_valid = trg_rise && run_r;
    assign ev_data  = {DIRECTION, SERIAL_IN};

    esr_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst       (RST),
        .in_data   (ev_data),
        .in_valid  (ev_valid),
        .in_ready  (ev_ready),
        .out_data  (stages_nxt[1:0]),
        .out_valid (shift_ok),
        .out_ready (1'b1),
        .count     (fifo_count)
    );
    assign fifo_full_n = ev_ready;

    // One queued event makes one shift per cycle; in a power-loss cycle the event popped is dropped unshifted.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stages_r <= `ESR_RST_STAGES;
        end else if (pwr_loss) begin
            if (!retain_r) begin
                stages_r <= `ESR_RST_STAGES;
            end                                          // all stages kept
        end else if (shift_ok) begin
            if (stages_nxt[1]) begin
                stages_r <= {stages_nxt[0], stages_r[7:1]};
            end else begin
                stages_r <= {stages_r[6:0], stages_nxt[0]};
            end
        end
    end

    // Unused upper bits of the next-value bundle are tied off for a single driver.
    assign stages_nxt[7:2] = 6'h00;

    // The tap is registered so the output comes straight from a flip-flop.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tap_out_r <= 1'b0;
        end else begin
            tap_out_r <= stages_r[tap_r];
        end
    end
    assign TAP_OUT = tap_out_r;
    assign STAGES  = stages_r;

    // Write channel capture: address and data may arrive in either order.
    assign do_write = aw_held_r && w_held_r && !b_valid_r;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= AWADDR;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_held_r <= 1'b1;
                w_data_r <= WDATA;
                w_strb_r <= WSTRB;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Ready outputs are registered; each drops as soon as its item is taken.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
        end else begin
            AWREADY <= !aw_held_r && !(AWVALID && AWREADY) && !b_valid_r;
            WREADY  <= !w_held_r && !(WVALID && WREADY) && !b_valid_r;
        end
    end

    // Register writes. Configuration is only accepted while not live editing.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            run_r    <= 1'(`ESR_RST_CTRL >> `ESR_CTRL_RUN);
            live_r   <= 1'b0;
            tap_r    <= `ESR_RST_TAP;
            retain_r <= `ESR_RST_RETAIN;
        end else if (do_write && w_strb_r[0]) begin
            if (aw_addr_r == `ESR_OFF_CTRL) begin
                run_r  <= w_data_r[`ESR_CTRL_RUN];
                live_r <= w_data_r[`ESR_CTRL_LIVE];
            end else if (aw_addr_r == `ESR_OFF_CONFIG && !live_r) begin
                tap_r    <= w_data_r[`ESR_CFG_TAP_HI:`ESR_CFG_TAP_LO];
                retain_r <= w_data_r[`ESR_CFG_RETAIN];
            end
        end
    end

    // Write response: unmapped or refused writes answer SLVERR.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            b_valid_r <= 1'b0;
            b_resp_r  <= `ESR_RESP_OKAY;
        end else if (do_write) begin
            b_valid_r <= 1'b1;
            if (aw_addr_r == `ESR_OFF_CTRL ||
                (aw_addr_r == `ESR_OFF_CONFIG && !live_r)) begin
                b_resp_r <= `ESR_RESP_OKAY;
            end else begin
                b_resp_r <= `ESR_RESP_SLVERR;
            end
        end else if (b_valid_r && BREADY) begin
            b_valid_r <= 1'b0;
        end
    end
    assign BVALID = b_valid_r;
    assign BRESP  = b_resp_r;

    // Read path: address taken, data answered on the next edge.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ARREADY   <= 1'b0;
            r_valid_r <= 1'b0;
            r_data_r  <= 32'h0000_0000;
            r_resp_r  <= `ESR_RESP_OKAY;
        end else begin
            ARREADY <= !r_valid_r && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                r_valid_r <= 1'b1;
                r_resp_r  <= `ESR_RESP_OKAY;
                case (ARADDR)
                    `ESR_OFF_CTRL: begin
                        r_data_r <= {29'h0, POWER_FAIL, live_r, run_r};
                    end
                    `ESR_OFF_CONFIG: begin
                        r_data_r <= {28'h0, retain_r, tap_r};
                    end
                    `ESR_OFF_STAGES: begin
                        r_data_r <= {24'h0, stages_r};
                    end
                    `ESR_OFF_STATUS: begin
                        r_data_r <= {19'h0, 5'(fifo_count), 5'h0, trg_prev_r,
                                     !shift_ok, !fifo_full_n};
                    end
                    default: begin
                        r_data_r <= 32'h0000_0000;
                        r_resp_r <= `ESR_RESP_SLVERR;
                    end
                endcase
            end else if (r_valid_r && RREADY) begin
                r_valid_r <= 1'b0;
            end
        end
    end
    assign RVALID = r_valid_r;
    assign RDATA  = r_data_r;
    assign RRESP  = r_resp_r;
endmodule : esr_shift_register // esr_shift_register

`default_nettype wire

// *** verilog/esr_map.svh ***
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define ESR_OFF_CTRL    12'h000
`define ESR_OFF_CONFIG  12'h004
`define ESR_OFF_STAGES  12'h008
`define ESR_OFF_STATUS  12'h00c

// Control register fields.
`define ESR_CTRL_RUN    0
`define ESR_CTRL_LIVE   1
`define ESR_CTRL_POWER  2

// Configuration register fields.
`define ESR_CFG_TAP_LO  0
`define ESR_CFG_TAP_HI  2
`define ESR_CFG_RETAIN  3

// Status register fields.
`define ESR_STAT_FULL   0
`define ESR_STAT_EMPTY  1
`define ESR_STAT_TRG    2
`define ESR_STAT_CNT_LO 8
`define ESR_STAT_CNT_HI 12

// Reset values.
`define ESR_RST_CTRL    3'h1
`define ESR_RST_TAP     3'h0
`define ESR_RST_RETAIN  1'h0
`define ESR_RST_STAGES  8'h00

// Answer codes of the bus.
`define ESR_RESP_OKAY   2'h0
`define ESR_RESP_SLVERR 2'h2

`endif

// *** verilog/esr_pkg.sv ***
package esr_pkg;
    typedef enum logic [1:0] {
        ESR_BUS_IDLE,
        ESR_BUS_RESP
    } esr_bus_state_type;

    typedef logic [7:0] esr_stages_type;
endpackage : esr_pkg

// *** verilog/esr_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none

module esr_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Push and pop only when the opposite side is able, so full and empty stay honest.
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign count     = count_r;

    // Storage is plain flip-flops addressed by the write pointer.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule : esr_fifo // esr_fifo

`default_nettype wire

// *** verif/esr_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

`include "esr_map.svh"

module esr_checker (
    input wire logic                    REF_CLK,
    input wire logic                    RST,
    input wire logic                    SERIAL_IN,
    input wire logic                    TRIGGER,
    input wire logic                    DIRECTION,
    input wire logic                    POWER_FAIL,
    input wire logic                    TAP_OUT,
    input wire esr_pkg::esr_stages_type STAGES,
    input wire logic [11:0]             AWADDR,
    input wire logic                    AWVALID,
    input wire logic [31:0]             WDATA,
    input wire logic                    WVALID,
    input wire logic [1:0]              BRESP,
    input wire logic                    BVALID,
    input wire logic                    BREADY
);
    import esr_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    logic           trg_q, rise_q, live_q, retain_q;
    logic [2:0]     tap_q, quiet_q;
    logic [11:0]    aw_q;
    logic [31:0]    w_q;
    esr_stages_type stg_q;
    logic           wr_ok;

    assign wr_ok = BVALID && BREADY && (BRESP == `ESR_RESP_OKAY);

    // Input history, kept so edges and tap delays can be judged a cycle later.
    always_ff @(posedge REF_CLK) begin
        trg_q <= TRIGGER;
        rise_q <= TRIGGER & ~trg_q;
        stg_q <= STAGES;
        if (AWVALID) aw_q <= AWADDR;
        if (WVALID) w_q <= WDATA;
    end

    // Shadow of the settings; the tap is trusted only once writes are quiet.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tap_q <= 3'h0;
            retain_q <= 1'b0;
            live_q <= 1'b0;
            quiet_q <= 3'h0;
        end else begin
            if (AWVALID) quiet_q <= 3'h0;
            else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
            if (wr_ok && aw_q == `ESR_OFF_CONFIG) tap_q <= w_q[2:0];
            if (wr_ok && aw_q == `ESR_OFF_CONFIG) retain_q <= w_q[3];
            if (wr_ok && aw_q == `ESR_OFF_CTRL) live_q <= w_q[1];
        end
    end

    sequence s_rise;
        !TRIGGER ##1 (TRIGGER && !POWER_FAIL);
    endsequence
    property p_up;
        s_rise ##0 !DIRECTION |-> ##2 STAGES == {$past(STAGES[6:0]), $past(SERIAL_IN, 2)};
    endproperty
    property p_down;
        s_rise ##0 DIRECTION |-> ##2 STAGES == {$past(SERIAL_IN, 2), $past(STAGES[7:1])};
    endproperty
    property p_fall;
        $fell(TRIGGER) && !POWER_FAIL |-> ##2 $stable(STAGES);
    endproperty
    property p_only_rise;
        $changed(STAGES) && !POWER_FAIL && !$past(POWER_FAIL) && !$past(POWER_FAIL, 2)
            |-> $past(rise_q);
    endproperty
    property p_tap;
        quiet_q == 3'h7 |-> TAP_OUT == stg_q[tap_q];
    endproperty
    property p_clear;
        $rose(POWER_FAIL) && !retain_q |-> ##[1:3] (STAGES == 8'h00);
    endproperty
    property p_keep;
        $rose(POWER_FAIL) && retain_q && !TRIGGER |=> $stable(STAGES) [*3];
    endproperty
    property p_lock;
        BVALID && live_q && aw_q == `ESR_OFF_CONFIG |-> BRESP == `ESR_RESP_SLVERR;
    endproperty

    a_up: assert property (p_up) else $error("shift up wrong");
    a_down: assert property (p_down) else $error("shift down wrong");
    a_fall: assert property (p_fall) else $error("falling edge shifted");
    a_only_rise: assert property (p_only_rise) else $error("shift without rise");
    a_tap: assert property (p_tap) else $error("tap output wrong");
    a_clear: assert property (p_clear) else $error("stages not cleared");
    a_keep: assert property (p_keep) else $error("stages not kept");
    a_lock: assert property (p_lock) else $error("config write not refused");
endmodule // esr_checker

bind esr_shift_register esr_checker esr_checker_i (.REF_CLK(REF_CLK), .RST(RST),
    .SERIAL_IN(SERIAL_IN), .TRIGGER(TRIGGER), .DIRECTION(DIRECTION), .POWER_FAIL(POWER_FAIL),
    .TAP_OUT(TAP_OUT), .STAGES(STAGES), .AWADDR(AWADDR), .AWVALID(AWVALID), .WDATA(WDATA),
    .WVALID(WVALID), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY));

`default_nettype wire

// *** verif/esr_prog_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module esr_prog_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       bit_in,
    input  wire logic       dir_in,
    input  wire logic [3:0] hi_len,
    output var  logic       trg = 1'b0,
    output var  logic       ser = 1'b0,
    output var  logic       dir = 1'b0,
    output var  logic       busy = 1'b0
);
    logic [3:0] cnt_r = 4'h0;

    // Only this one program drives the trigger, data and direction inputs; the data bit flips while held high.
    always_ff @(posedge clk) begin
        if (go && !busy) begin
            ser <= bit_in;
            dir <= dir_in;
            cnt_r <= hi_len;
            trg <= 1'b1;
            busy <= 1'b1;
        end else if (busy) begin
            ser <= ~ser;
            cnt_r <= cnt_r - 4'h1;
            trg <= (cnt_r != 4'h0);
            busy <= (cnt_r != 4'h0);
        end
    end
endmodule // esr_prog_model

`default_nettype wire

// *** verif/eight_stage_shift_register_test.sv ***
`timescale 1ns/100ps
`default_nettype none

`include "esr_map.svh"

module eight_stage_shift_register_test;
    import esr_pkg::*;
    logic           REF_CLK = 1'b0, RST = 1'b1, POWER_FAIL = 1'b0;
    logic           go = 1'b0, bit_v = 1'b0, dir_v = 1'b0;
    logic [3:0]     hi = 4'h0;
    logic [11:0]    AWADDR = 12'h000, ARADDR = 12'h000;
    logic [31:0]    WDATA = 32'h0, d;
    logic           AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    wire            ser, trg, dir, busy, TAP_OUT, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire [1:0]      BRESP, RRESP;
    wire [31:0]     RDATA;
    wire esr_stages_type STAGES;
    esr_stages_type exp_s = 8'h00;
    logic [2:0]     tap = 3'h0;
    logic [1:0]     r;
    int             mismatches = 0, total_checks = 0;

    // Free-running 50 MHz clock.
    always #10 REF_CLK = ~REF_CLK;

    esr_shift_register #(.FIFO_DEPTH(16)) esr_shift_register_i (.REF_CLK(REF_CLK), .RST(RST),
        .SERIAL_IN(ser), .TRIGGER(trg), .DIRECTION(dir), .POWER_FAIL(POWER_FAIL),
        .TAP_OUT(TAP_OUT), .STAGES(STAGES), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    esr_prog_model esr_prog_model_i (.clk(REF_CLK), .go(go), .bit_in(bit_v), .dir_in(dir_v),
        .hi_len(hi), .trg(trg), .ser(ser), .dir(dir), .busy(busy));

    task automatic chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: value differs", $time);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        @(posedge REF_CLK);
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1 && n < 100);
        rs = BRESP;
        BREADY <= 1'b0;
        chk(n < 100);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        @(posedge REF_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1 && n < 100);
        rs = RRESP;
        v = RDATA;
        RREADY <= 1'b0;
        chk(n < 100);
    endtask

    // One trigger pulse held for h extra cycles; judged after the pulse has ended.
    task automatic shift(input logic b, input logic dr, input logic [3:0] h);
        @(posedge REF_CLK);
        bit_v <= b;
        dir_v <= dr;
        hi <= h;
        go <= 1'b1;
        @(posedge REF_CLK);
        go <= 1'b0;
        do @(posedge REF_CLK); while (busy);
        repeat (3) @(posedge REF_CLK);
        exp_s = dr ? {b, exp_s[7:1]} : {exp_s[6:0], b};
        chk(STAGES === exp_s);
        chk(TAP_OUT === exp_s[tap]);
    endtask

    task automatic final_report;
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence: reset, shifting, taps, live editing, power loss.
    initial begin
        repeat (12) @(posedge REF_CLK);
        RST <= 1'b0;
        rd(`ESR_OFF_CONFIG, d, r);
        chk(d[3:0] === 4'h0);
        rd(12'h010, d, r);
        chk(r === `ESR_RESP_SLVERR);
        shift(1'b1, 1'b0, 4'h0);
        shift(1'b0, 1'b0, 4'h2);
        shift(1'b1, 1'b0, 4'h0);
        shift(1'b1, 1'b0, 4'h5);
        rd(`ESR_OFF_STAGES, d, r);
        chk(d[7:0] === exp_s);
        rd(`ESR_OFF_STATUS, d, r);
        chk(d[1:0] === 2'h2);
        for (int k = 0; k < 8; k++) begin
            wr(`ESR_OFF_CONFIG, k, r);
            tap = k[2:0];
            repeat (3) @(posedge REF_CLK);
            chk(TAP_OUT === exp_s[k]);
        end
        shift(1'b0, 1'b1, 4'h0);
        shift(1'b1, 1'b1, 4'h3);
        wr(`ESR_OFF_CTRL, 32'h3, r);
        chk(r === `ESR_RESP_OKAY);
        wr(`ESR_OFF_CONFIG, 32'h8, r);
        chk(r === `ESR_RESP_SLVERR);
        rd(`ESR_OFF_CONFIG, d, r);
        chk(d[3:0] === {1'b0, tap});
        shift(1'b1, 1'b0, 4'h0);
        wr(`ESR_OFF_CTRL, 32'h1, r);
        chk(r === `ESR_RESP_OKAY);
        wr(`ESR_OFF_CONFIG, {28'h0, 1'b1, tap}, r);
        POWER_FAIL <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        chk(STAGES === exp_s);
        POWER_FAIL <= 1'b0;
        wr(`ESR_OFF_CONFIG, {29'h0, tap}, r);
        POWER_FAIL <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        exp_s = 8'h00;
        chk(STAGES === 8'h00);
        POWER_FAIL <= 1'b0;
        shift(1'b1, 1'b0, 4'h0);
        final_report();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge REF_CLK);
        mismatches++;
        final_report();
    end
endmodule // eight_stage_shift_register_test

`default_nettype wire
